// ===== usm_pkg.sv
// shared constants, carrier structs and state layout for the serial port status block
package usm_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;

  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IEN = 3'h1;
  localparam logic [2:0] REG_FIFO = 3'h2;
  localparam logic [2:0] REG_LINE = 3'h3;
  localparam logic [2:0] REG_MODEM_CTL = 3'h4;
  localparam logic [2:0] REG_LINE_STAT = 3'h5;
  localparam logic [2:0] REG_MODEM_STAT = 3'h6;
  localparam logic [2:0] REG_SCRATCH = 3'h7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LINE_DIV_SEL = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_LOOP_RI = 2;
  localparam int MC_IRQ_EN = 3;
  localparam int MC_LOOP = 4;
  localparam int FC_ENABLE = 0;
  localparam int FC_RX_RESET = 1;
  localparam int FC_TX_RESET = 2;
  localparam int IE_RX_READY = 0;
  localparam int IE_HOLD_EMPTY = 1;
  localparam int IE_LINE_STAT = 2;
  localparam int IE_MODEM_STAT = 3;
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_RI = 2;
  localparam int MS_DCD = 3;

  // ---------------------------------------------------------------
  // fifo geometry and reset values
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] CAP_FIFO = 5'h10;
  localparam logic [4:0] CAP_SINGLE = 5'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;

  // ---------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic silent;
    logic stop_err;
    logic parity_err;
    logic [7:0] data;
  } usm_rx_char_s;

  typedef struct packed {
    logic silent;
    logic stop_err;
    logic parity_err;
    logic [7:0] data;
  } usm_rx_entry_s;

  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } usm_modem_in_s;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] line_format;
    logic [4:0] modem_control;
    logic [3:0] irq_enable;
    logic [7:0] scratch_byte;
    logic fifo_en;
    usm_rx_entry_s [FIFO_DEPTH-1:0] rxf;
    logic [3:0] rx_rp;
    logic [3:0] rx_wp;
    logic [4:0] rx_cnt;
    logic [FIFO_DEPTH-1:0][7:0] txf;
    logic [3:0] tx_rp;
    logic [3:0] tx_wp;
    logic [4:0] tx_cnt;
    logic overrun_flag;
    logic silent_line_flag;
    logic missing_stop_flag;
    logic parity_error_flag;
    logic rx_fifo_error_flag;
    logic holding_empty_flag;
    logic [3:0] modem_prev;
    logic [3:0] modem_delta;
    logic bus_wait;
    logic [7:0] rdata;
    logic irq;
    logic serial_out;
    logic rx_serial;
    logic rts_n;
    logic dtr_n;
    logic tx_valid;
    logic [7:0] tx_data;
  } usm_state_s;

  localparam usm_state_s USM_RST = '{
    bus_wait: 1'b1,
    holding_empty_flag: 1'b1,
    serial_out: 1'b1,
    rx_serial: 1'b1,
    rts_n: 1'b1,
    dtr_n: 1'b1,
    default: '0
  };

endpackage

// ===== usm_status_modem.sv
// register map, line status, modem handshake and loopback of the serial port
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps

// Behaviour
// [RULE1] fifo mode: parity error held sets bit7
// [RULE2] status read clears bit7 when no errors remain
// [RULE3] bit6 set when holding and shifter empty
// [RULE4] bit5 sets on holding drain, clears on write
// [RULE5] holding empty with enable raises interrupt
// [RULE6] bit4 reports silent line for whole character
// [RULE7] bit3 reports missing stop bit
// [RULE8] bit2 reports wrong parity bit
// [RULE9] fifo mode error flags follow head entry
// [RULE10] bit1 reports overwrite of unread character
// [RULE11] bit0 high while received data waits
// [RULE12] loopback drives output high, ignores input
// [RULE13] loopback forces modem outputs inactive
// [RULE14] loopback feeds modem inputs from control bits
// [RULE15] control bit3 gates the interrupt output
// [RULE16] control bits drive inverted rts and dtr
// [RULE17] status high nibble shows inverted modem inputs
// [RULE18] carrier, ready, clear changes set delta bits
// [RULE19] ring trailing edge sets delta bit2
// [RULE20] characters travel least significant bit first
// [RULE21] fifo indications read zero when unbuffered
// [RULE22] fifo mode only while enable bit set
// [RULE23] divisor select remaps offsets zero and one
// [RULE24] modem status read clears delta bits
module usm_status_modem (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire usm_pkg::usm_rx_char_s i_rx_char,
  input wire logic i_tx_load,
  input wire logic i_tx_shift_empty,
  input wire logic i_tx_serial,
  input wire logic i_serial_in,
  input wire usm_pkg::usm_modem_in_s i_modem_n,
  output logic o_serial_out,
  output logic o_rx_serial,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_irq,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic [15:0] o_divisor,
  output logic [6:0] o_line_format,
  output logic o_fifo_enable
);
  import usm_pkg::*;

  usm_state_s q;
  usm_state_s d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic commit;
    logic wr;
    logic rd;
    logic [2:0] idx;
    logic div_sel;
    logic loop;
    logic [4:0] cap;
    logic rx_rst;
    logic tx_rst;
    logic pop_rx;
    logic overwrite;
    logic new_head;
    logic any_pe;
    logic [3:0] pos;
    logic [3:0] mstat;
    logic temt;
    logic p_ls;
    logic p_rd;
    logic p_th;
    logic p_ms;
    logic [1:0] int_id;
    logic [7:0] line_stat;
    usm_rx_entry_s head;
    d = q;
    commit = (i_avs_read | i_avs_write) & ~q.bus_wait;
    wr = commit & i_avs_write & i_avs_byteenable[0];
    rd = commit & i_avs_read;
    idx = i_avs_address[4:2];
    div_sel = q.line_format[LINE_DIV_SEL];
    loop = q.modem_control[MC_LOOP];
    cap = q.fifo_en ? CAP_FIFO : CAP_SINGLE; // RULE22
    rx_rst = 1'b0;
    tx_rst = 1'b0;
    overwrite = 1'b0;
    any_pe = 1'b0;
    pos = 4'h0;
    head = q.rxf[q.rx_rp];
    temt = (q.tx_cnt == 5'h00) & i_tx_shift_empty; // RULE3
    p_ls = q.irq_enable[IE_LINE_STAT] & (q.overrun_flag | q.silent_line_flag |
           q.missing_stop_flag | q.parity_error_flag);
    p_rd = q.irq_enable[IE_RX_READY] & (q.rx_cnt != 5'h00);
    p_th = q.irq_enable[IE_HOLD_EMPTY] & q.holding_empty_flag; // RULE5
    p_ms = q.irq_enable[IE_MODEM_STAT] & (q.modem_delta != 4'h0);
    int_id = p_ls ? 2'h3 : p_rd ? 2'h2 : p_th ? 2'h1 : 2'h0;
    line_stat = {q.rx_fifo_error_flag & q.fifo_en, temt, q.holding_empty_flag,
                 q.silent_line_flag, q.missing_stop_flag, q.parity_error_flag,
                 q.overrun_flag, q.rx_cnt != 5'h00}; // RULE11

    // ---------------------------------------------------------------
    // bus slave: one wait cycle, then the access commits
    // ---------------------------------------------------------------
    if ((i_avs_read | i_avs_write) & q.bus_wait) begin
      d.bus_wait = 1'b0;
      case (idx)
        REG_DATA: d.rdata = div_sel ? q.divisor[7:0] : head.data; // RULE23 RULE20
        REG_IEN: d.rdata = div_sel ? q.divisor[15:8] : {4'h0, q.irq_enable}; // RULE23
        REG_FIFO: d.rdata = {q.fifo_en, q.fifo_en, 3'h0, int_id,
                             ~(p_ls | p_rd | p_th | p_ms)}; // RULE21
        REG_LINE: d.rdata = q.line_format;
        REG_MODEM_CTL: d.rdata = {3'h0, q.modem_control};
        REG_LINE_STAT: d.rdata = line_stat;
        REG_MODEM_STAT: d.rdata = {q.modem_prev, q.modem_delta};
        REG_SCRATCH: d.rdata = q.scratch_byte;
        default: d.rdata = RST_BYTE;
      endcase
    end
    if (commit) begin
      d.bus_wait = 1'b1;
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (wr) begin
      case (idx)
        REG_DATA: begin
          if (div_sel) begin
            d.divisor[7:0] = i_avs_writedata[7:0]; // RULE23
          end
        end
        REG_IEN: begin
          if (div_sel) begin
            d.divisor[15:8] = i_avs_writedata[7:0]; // RULE23
          end else begin
            d.irq_enable = i_avs_writedata[3:0];
          end
        end
        REG_FIFO: begin
          d.fifo_en = i_avs_writedata[FC_ENABLE]; // RULE22
          rx_rst = i_avs_writedata[FC_RX_RESET] | (d.fifo_en != q.fifo_en);
          tx_rst = i_avs_writedata[FC_TX_RESET] | (d.fifo_en != q.fifo_en);
        end
        REG_LINE: d.line_format = i_avs_writedata[7:0];
        REG_MODEM_CTL: d.modem_control = i_avs_writedata[4:0];
        REG_SCRATCH: d.scratch_byte = i_avs_writedata[7:0];
        default: d.scratch_byte = q.scratch_byte;
      endcase
    end

    // ---------------------------------------------------------------
    // clear on read, using the value the reader saw
    // ---------------------------------------------------------------
    if (rd && idx == REG_LINE_STAT) begin
      if (q.rdata[1]) begin
        d.overrun_flag = 1'b0; // RULE10
      end
      if (q.rdata[2]) begin
        d.parity_error_flag = 1'b0; // RULE8
      end
      if (q.rdata[3]) begin
        d.missing_stop_flag = 1'b0; // RULE7
      end
      if (q.rdata[4]) begin
        d.silent_line_flag = 1'b0; // RULE6
      end
    end
    if (rd && idx == REG_MODEM_STAT) begin
      d.modem_delta = q.modem_delta & ~q.rdata[3:0]; // RULE24
    end
    if (rd && idx == REG_FIFO && q.rdata[2:0] == 3'h2) begin
      d.holding_empty_flag = 1'b0;
    end

    // ---------------------------------------------------------------
    // receive buffer: depth one unbuffered, sixteen in fifo mode
    // ---------------------------------------------------------------
    pop_rx = rd & (idx == REG_DATA) & ~div_sel & (q.rx_cnt != 5'h00);
    if (rx_rst) begin
      d.rx_rp = 4'h0;
      d.rx_wp = 4'h0;
      d.rx_cnt = 5'h00;
    end else begin
      if (pop_rx) begin
        d.rx_rp = q.rx_rp + 4'h1;
        d.rx_cnt = q.rx_cnt - 5'h01;
      end
      if (i_rx_char.valid) begin
        if (d.rx_cnt < cap) begin
          d.rxf[d.rx_wp] = i_rx_char[10:0];
          d.rx_wp = d.rx_wp + 4'h1;
          d.rx_cnt = d.rx_cnt + 5'h01;
        end else begin
          d.overrun_flag = 1'b1; // RULE10
          if (!q.fifo_en) begin
            overwrite = 1'b1;
            d.rxf[d.rx_rp] = i_rx_char[10:0];
          end
        end
      end
    end
    new_head = pop_rx | (i_rx_char.valid & (q.rx_cnt == 5'h00)) | overwrite;
    if (new_head && d.rx_cnt != 5'h00 && !rx_rst) begin
      head = d.rxf[d.rx_rp];
      d.silent_line_flag = d.silent_line_flag | head.silent; // RULE6 RULE9
      d.missing_stop_flag = d.missing_stop_flag | head.stop_err; // RULE7 RULE9
      d.parity_error_flag = d.parity_error_flag | head.parity_err; // RULE8 RULE9
    end
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      pos = d.rx_rp + i[3:0];
      if (i[4:0] < d.rx_cnt && d.rxf[pos].parity_err) begin
        any_pe = 1'b1;
      end
    end
    d.rx_fifo_error_flag = d.fifo_en & (any_pe | (q.rx_fifo_error_flag &
                           ~(rd && idx == REG_LINE_STAT))); // RULE1 RULE2 RULE21

    // ---------------------------------------------------------------
    // transmit holding stage
    // ---------------------------------------------------------------
    if (tx_rst) begin
      d.tx_rp = 4'h0;
      d.tx_wp = 4'h0;
      d.tx_cnt = 5'h00;
      d.holding_empty_flag = 1'b1;
    end else begin
      if (i_tx_load && q.tx_cnt != 5'h00) begin
        d.tx_rp = q.tx_rp + 4'h1;
        d.tx_cnt = q.tx_cnt - 5'h01;
      end
      if (wr && idx == REG_DATA && !div_sel) begin
        d.holding_empty_flag = 1'b0; // RULE4
        if (d.tx_cnt < cap) begin
          d.txf[d.tx_wp] = i_avs_writedata[7:0];
          d.tx_wp = d.tx_wp + 4'h1;
          d.tx_cnt = d.tx_cnt + 5'h01;
        end
      end
      if (i_tx_load && q.tx_cnt != 5'h00 && d.tx_cnt == 5'h00) begin
        d.holding_empty_flag = 1'b1; // RULE4
      end
    end
    d.tx_valid = d.tx_cnt != 5'h00;
    d.tx_data = d.txf[d.tx_rp]; // RULE20

    // ---------------------------------------------------------------
    // modem inputs, change detection and pins
    // ---------------------------------------------------------------
    if (loop) begin
      mstat = {q.modem_control[MC_IRQ_EN], q.modem_control[MC_LOOP_RI],
               q.modem_control[MC_DTR], q.modem_control[MC_RTS]}; // RULE14 RULE15 RULE17
    end else begin
      mstat = ~{i_modem_n.dcd_n, i_modem_n.ri_n, i_modem_n.dsr_n, i_modem_n.cts_n}; // RULE17
    end
    d.modem_prev = mstat;
    d.modem_delta[MS_DCD] = d.modem_delta[MS_DCD] | (mstat[MS_DCD] ^ q.modem_prev[MS_DCD]); // RULE18
    d.modem_delta[MS_RI] = d.modem_delta[MS_RI] | (q.modem_prev[MS_RI] & ~mstat[MS_RI]); // RULE19
    d.modem_delta[MS_DSR] = d.modem_delta[MS_DSR] | (mstat[MS_DSR] ^ q.modem_prev[MS_DSR]); // RULE18
    d.modem_delta[MS_CTS] = d.modem_delta[MS_CTS] | (mstat[MS_CTS] ^ q.modem_prev[MS_CTS]); // RULE18

    d.rts_n = d.modem_control[MC_LOOP] | ~d.modem_control[MC_RTS]; // RULE16 RULE13
    d.dtr_n = d.modem_control[MC_LOOP] | ~d.modem_control[MC_DTR]; // RULE16 RULE13
    d.serial_out = d.modem_control[MC_LOOP] | i_tx_serial; // RULE12
    d.rx_serial = d.modem_control[MC_LOOP] ? i_tx_serial : i_serial_in; // RULE12 RULE13
    d.irq = q.modem_control[MC_IRQ_EN] & (p_ls | p_rd | p_th | p_ms); // RULE15 RULE5
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= USM_RST;
    end else begin
      q <= d;
    end
  end

  assign o_avs_readdata = {24'h000000, q.rdata};
  assign o_avs_waitrequest = q.bus_wait;
  assign o_serial_out = q.serial_out;
  assign o_rx_serial = q.rx_serial;
  assign o_rts_n = q.rts_n;
  assign o_dtr_n = q.dtr_n;
  assign o_irq = q.irq;
  assign o_tx_valid = q.tx_valid;
  assign o_tx_data = q.tx_data;
  assign o_divisor = q.divisor;
  assign o_line_format = q.line_format[6:0];
  assign o_fifo_enable = q.fifo_en;

endmodule

// ===== usm_monitor.sv
// port checker for the serial port status block
`timescale 1ns/1ps
module usm_monitor (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_tx_serial,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_rx_serial,
  input wire logic o_rts_n,
  input wire logic o_dtr_n,
  input wire logic o_irq
);
  import usm_pkg::*;
  // ---------------------------------------------------------------
  // shadow of the modem control byte
  // ---------------------------------------------------------------
  logic [4:0] mc_q;
  logic [4:0] mc_d;
  always_comb begin
    mc_d = mc_q;
    if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
        i_avs_address[4:2] == REG_MODEM_CTL) begin
      mc_d = i_avs_writedata[4:0];
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mc_q <= '0;
    end else begin
      mc_q <= mc_d;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("access not answered after one wait");
  a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_rdata_upper: assert property (i_avs_read && !o_avs_waitrequest
    |-> o_avs_readdata[31:8] == 24'h0) else $error("upper read data not zero");
  // pins follow the control byte written in the same edge, so compare with the shadow now
  a_loop_out: assert property (mc_q[4] |-> o_serial_out)
    else $error("serial out not high in loopback");
  a_normal_out: assert property ($past(i_nrst) && !mc_q[4]
    |-> o_serial_out == $past(i_tx_serial)) else $error("serial out path wrong");
  a_rx_route: assert property ($past(i_nrst) |-> o_rx_serial ==
    (mc_q[4] ? $past(i_tx_serial) : $past(i_serial_in)))
    else $error("receive line source wrong");
  a_rts_inverse: assert property (!mc_q[4] |->
    o_rts_n == !mc_q[1] && o_dtr_n == !mc_q[0])
    else $error("handshake outputs not inverted control");
  a_loop_modem: assert property (mc_q[4] |-> o_rts_n && o_dtr_n)
    else $error("modem outputs active in loopback");
  a_irq_gate: assert property (!$past(mc_q[3]) |-> !o_irq)
    else $error("interrupt raised while gated off");
endmodule

bind usm_status_modem usm_monitor u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_tx_serial(i_tx_serial), .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
  .o_rx_serial(o_rx_serial), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_irq(o_irq));

// ===== usm_modem_peer.sv
// modem peer: answers request and ready outputs after a chosen lag
`timescale 1ns/1ps
module usm_modem_peer (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rts_n,
  input wire logic i_dtr_n,
  input wire logic [3:0] i_lag,
  input wire logic i_dcd_n,
  input wire logic i_ri_n,
  output usm_pkg::usm_modem_in_s o_modem_n
);
  import usm_pkg::*;
  logic [15:0] rts_q;
  logic [15:0] dtr_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rts_q <= '1;
      dtr_q <= '1;
    end else begin
      rts_q <= {rts_q[14:0], i_rts_n};
      dtr_q <= {dtr_q[14:0], i_dtr_n};
    end
  end
  assign o_modem_n = '{dcd_n: i_dcd_n, ri_n: i_ri_n, dsr_n: dtr_q[i_lag], cts_n: rts_q[i_lag]};
endmodule

// ===== test_usm_status_modem.sv
// register level test of the serial port status block
`timescale 1ns/1ps
module test_usm_status_modem;
  import usm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic [3:0] be = 4'h1;
  usm_rx_char_s rxc = '0;
  logic ld = 1'b0;
  logic sh_e = 1'b1;
  logic dcd = 1'b1;
  logic ri = 1'b1;
  logic [3:0] lag = 4'h5;
  logic [7:0] cnt = 8'h00;
  usm_modem_in_s modem;
  logic [31:0] rdata;
  logic wq, so, rts, dtr, irq, txv;
  logic [7:0] txd;
  logic [7:0] rq;
  logic [15:0] dv;
  int errors = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 8'h01;
  usm_status_modem dut (.i_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata({24'h0, wdat}),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
    .i_rx_char(rxc), .i_tx_load(ld), .i_tx_shift_empty(sh_e), .i_tx_serial(cnt[0]),
    .i_serial_in(cnt[2]), .i_modem_n(modem), .o_serial_out(so), .o_rx_serial(),
    .o_rts_n(rts), .o_dtr_n(dtr), .o_irq(irq), .o_tx_valid(txv), .o_tx_data(txd),
    .o_divisor(dv), .o_line_format(), .o_fifo_enable());
  usm_modem_peer peer (.i_clk(clk), .i_nrst(nrst), .i_rts_n(rts), .i_dtr_n(dtr),
    .i_lag(lag), .i_dcd_n(dcd), .i_ri_n(ri), .o_modem_n(modem));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; waitrequest is registered, so its negedge value is the edge value
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    adr <= {a, 2'b00};
    wdat <= d;
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      errors++;
      stop_test();
    end
    rq = rdata[7:0];
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
    bus(1'b0, a, 8'h00);
    chk8(rq & m, exp);
  endtask
  task automatic rxp(input logic [10:0] f);
    rxc <= {1'b1, f};
    @(posedge clk);
    rxc <= '0;
    repeat (3) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b1, REG_SCRATCH, 8'ha5);
    be <= 4'h0;
    bus(1'b1, REG_SCRATCH, 8'h5a);
    be <= 4'h1;
    rdc(REG_SCRATCH, 8'ha5, 8'hff);
    rdc(REG_LINE_STAT, 8'h60, 8'hff);
    rdc(REG_FIFO, 8'h01, 8'hff);
    bus(1'b1, REG_DATA, 8'h3c);
    rdc(REG_LINE_STAT, 8'h00, 8'hff);
    chk8(txd, 8'h3c);
    chk1(txv, 1'b1);
    sh_e <= 1'b0;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    @(posedge clk);
    rdc(REG_LINE_STAT, 8'h20, 8'hff);
    sh_e <= 1'b1;
    rdc(REG_LINE_STAT, 8'h60, 8'hff);
    bus(1'b1, REG_IEN, 8'h02);
    @(negedge clk);
    chk1(irq, 1'b0);
    @(posedge clk);
    bus(1'b1, REG_MODEM_CTL, 8'h08);
    @(negedge clk);
    chk1(irq, 1'b1);
    @(posedge clk);
    rdc(REG_FIFO, 8'h02, 8'hff);
    rdc(REG_LINE_STAT, 8'h40, 8'hff);
    bus(1'b1, REG_IEN, 8'h00);
    rxp(11'h15a);
    rdc(REG_LINE_STAT, 8'h45, 8'hff);
    rdc(REG_LINE_STAT, 8'h41, 8'hff);
    rxp(11'h677);
    rdc(REG_LINE_STAT, 8'h5b, 8'hff);
    rdc(REG_DATA, 8'h77, 8'hff);
    rdc(REG_LINE_STAT, 8'h40, 8'hff);
    bus(1'b1, REG_FIFO, 8'h01);
    rxp(11'h022);
    rxp(11'h111);
    rdc(REG_LINE_STAT, 8'hc1, 8'hdf);
    rdc(REG_DATA, 8'h22, 8'hff);
    rdc(REG_LINE_STAT, 8'hc5, 8'hdf);
    rdc(REG_LINE_STAT, 8'hc1, 8'hdf);
    rdc(REG_DATA, 8'h11, 8'hff);
    rdc(REG_LINE_STAT, 8'hc0, 8'hdf);
    rdc(REG_LINE_STAT, 8'h40, 8'hdf);
    rdc(REG_FIFO, 8'hc0, 8'hf0);
    bus(1'b1, REG_FIFO, 8'h00);
    rdc(REG_FIFO, 8'h00, 8'hf0);
    bus(1'b1, REG_LINE, 8'h80);
    bus(1'b1, REG_DATA, 8'h34);
    bus(1'b1, REG_IEN, 8'h12);
    rdc(REG_DATA, 8'h34, 8'hff);
    rdc(REG_IEN, 8'h12, 8'hff);
    chk8(dv[15:8], 8'h12);
    bus(1'b1, REG_LINE, 8'h00);
    rdc(REG_IEN, 8'h00, 8'hff);
    bus(1'b0, REG_MODEM_STAT, 8'h00);
    bus(1'b1, REG_MODEM_CTL, 8'h03);
    repeat (8) @(posedge clk);
    rdc(REG_MODEM_STAT, 8'h33, 8'hff);
    rdc(REG_MODEM_STAT, 8'h30, 8'hff);
    dcd <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(REG_MODEM_STAT, 8'hb8, 8'hff);
    ri <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(REG_MODEM_STAT, 8'hf0, 8'hff);
    ri <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(REG_MODEM_STAT, 8'hb4, 8'hff);
    rdc(REG_MODEM_STAT, 8'hb0, 8'hff);
    bus(1'b1, REG_MODEM_CTL, 8'h1d);
    dcd <= 1'b1;
    rdc(REG_MODEM_STAT, 8'he0, 8'hf0);
    @(negedge clk);
    chk1(rts, 1'b1);
    chk1(so, 1'b1);
    @(posedge clk);
    bus(1'b1, REG_MODEM_CTL, 8'h00);
    stop_test();
  end
endmodule
